// file: nvsc_pkg.sv
package nvsc_pkg;

  // Bus widths
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int DEPTH  = 2048;

  // Core clock period in ns
  localparam int CLK_PERIOD_NS = 8;

  // Access timing, ns (setup and strobe widths, address access time)
  localparam int SETUP_NS      = 5;
  localparam int STROBE_NS     = 20;
  localparam int ACCESS_NS     = 45;
  // Nonvolatile timing
  localparam int STORE_MS      = 10;
  localparam int RECALL_US     = 20;
  localparam int RESTORE_US    = 550;

  // Cycle counts, least times round up
  localparam int SETUP_CYC   = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC  = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC  = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STORE_CYC   = (STORE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECALL_CYC  = (RECALL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESTORE_CYC = (RESTORE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CNT_W = 24;

  // Host commands
  typedef enum logic [2:0]
  {
    CMD_READ   = 3'h0,
    CMD_WRITE  = 3'h1,
    CMD_STORE  = 3'h2,
    CMD_RECALL = 3'h3
  } nvsc_cmd_e;

  // Pin group toward the memory, all active low controls
  typedef struct packed
  {
    logic              chip_sel_n;
    logic              write_en_n;
    logic              out_en_n;
    logic              nonvolatile_select_n;
  } nvsc_ctl_s;

  localparam nvsc_ctl_s CTL_IDLE = '{chip_sel_n: 1'b1, write_en_n: 1'b1, out_en_n: 1'b1,
                                     nonvolatile_select_n: 1'b1};

  typedef enum logic [3:0]
  {
    ST_BOOT   = 4'h0,
    ST_IDLE   = 4'h1,
    ST_SETUP  = 4'h3,
    ST_STROBE = 4'h2,
    ST_HOLD   = 4'h6,
    ST_BUSY   = 4'h7,
    ST_DONE   = 4'h5
  } nvsc_state_e;

endpackage : nvsc_pkg

// file: nvsc_ctrl.sv
`timescale 1ns/100ps
// Operation
// R01: Nonvolatile select high for SRAM access, low only for store or recall.
// R02: Read drives chip select and output enable low, others high, at address.
// R03: Read data sampled after address access time with address held stable.
// R04: Write drops chip select and write enable with nonvolatile select high.
// R05: Address held stable from before write until write enable rises.
// R06: Output enable held high through every write; data driven only then.
// R07: Store drives nonvolatile select, chip select, write enable low, output enable high.
// R08: Store entered with write enable as the last control to fall.
// R09: Store erase and program happen inside the device; host just waits.
// R10: No access issued and bus released while a store runs.
// R11: Device read after store ends marks completion; host times it instead.
// R12: Recall puts chip select, output enable, nonvolatile select low, write enable high.
// R13: Recall waits 20 us before any further access.
// R14: After recall the controls return to idle, never a stray access.
// R15: Recall clears then reloads SRAM inside the device; repeatable freely.
// R16: Recall state held at least 20 ns, then released.
// R17: Write enable kept high throughout recall so no store starts.
// R18: Controls return to idle between operations so each one is a new transition.
// R19: Device runs a power-up recall of up to 550 us.
// R20: No access issued until the power-up recall time has passed after reset.
// R21: Write enable and chip select held high during the power-up recall.
// R22: Device refuses stores at low supply; host has no supply view.
// R23: Store state held at least 20 ns, then 10 ms waited.
// R24: Busy output covers the worst-case store or recall duration.
module nvsc_ctrl
  import nvsc_pkg::*;
#(
  parameter int STORE_WAIT   = STORE_CYC,
  parameter int RESTORE_WAIT = RESTORE_CYC,
  parameter int RECALL_WAIT  = RECALL_CYC
)
(
  // Clock and reset
  input  wire logic              I_CORE_CLK,
  input  wire logic              I_RST,
  // Host command port
  input  wire logic              I_REQ_VALID,
  input  wire nvsc_cmd_e         I_REQ_CMD,
  input  wire logic [ADDR_W-1:0] I_REQ_ADDR,
  input  wire logic [DATA_W-1:0] I_REQ_WDATA,
  output logic                   O_REQ_READY,
  output logic                   O_RSP_VALID,
  output logic [DATA_W-1:0]      O_RSP_RDATA,
  output logic                   O_BUSY,
  // Memory pins
  output nvsc_ctl_s              O_MEM_CTL,
  output logic [ADDR_W-1:0]      O_ADDR_BUS,
  input  wire logic [DATA_W-1:0] I_DATA_BUS,
  output logic [DATA_W-1:0]      O_DATA_BUS,
  output logic                   O_DATA_BUS_OE
);

  ////////////////////////////////////////////////////////////////////////
  nvsc_state_e     state_q;
  nvsc_cmd_e       cmd_q;
  logic [CNT_W-1:0] cnt_q;
  logic            cnt_zero;

  assign cnt_zero = (cnt_q == '0);

  // Control pattern wanted in the strobe phase of each command
  function automatic nvsc_ctl_s strobe_ctl(input nvsc_cmd_e c);
    nvsc_ctl_s r;
    r = CTL_IDLE;
    r.chip_sel_n = 1'b0;
    unique case (c)
      CMD_READ:   r.out_en_n = 1'b0;                              // see R02
      CMD_WRITE:  r.write_en_n = 1'b0;                            // see R04 see R06
      CMD_STORE:
      begin
        r.write_en_n           = 1'h0;                            // see R07
        r.nonvolatile_select_n = 1'h0;
      end
      CMD_RECALL:
      begin
        r.out_en_n             = 1'h0;                            // see R12 see R17
        r.nonvolatile_select_n = 1'h0;
      end
      default:    r = CTL_IDLE;
    endcase
    return r;
  endfunction : strobe_ctl

  // Setup phase: everything but the final strobe already in place
  // One late edge per start, so the memory sees a single clean transition
  function automatic nvsc_ctl_s setup_ctl(input nvsc_cmd_e c);
    nvsc_ctl_s r;
    r = strobe_ctl(c);
    if (c == CMD_STORE)
      r.write_en_n = 1'b1;                                        // see R08
    else
      r.chip_sel_n = 1'b1;
    return r;
  endfunction : setup_ctl

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
    begin
      state_q <= ST_BOOT;
      cnt_q   <= CNT_W'(RESTORE_WAIT);                            // see R19 see R20
      cmd_q   <= CMD_READ;
    end
    else
    begin
      unique case (state_q)
        ST_BOOT:
        begin
          if (cnt_zero)
            state_q <= ST_IDLE;
          else
            cnt_q <= cnt_q - 1'b1;
        end
        ST_IDLE:
        begin
          if (I_REQ_VALID)
          begin
            cmd_q   <= I_REQ_CMD;
            cnt_q   <= CNT_W'(SETUP_CYC);
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP:
        begin
          if (cnt_zero)
          begin
            cnt_q   <= (cmd_q == CMD_READ) ? CNT_W'(ACCESS_CYC) : CNT_W'(STROBE_CYC);
            state_q <= ST_STROBE;
          end
          else
            cnt_q <= cnt_q - 1'b1;
        end
        ST_STROBE:
        begin
          if (cnt_zero)
          begin
            cnt_q   <= CNT_W'(SETUP_CYC);
            state_q <= ST_HOLD;
          end
          else
            cnt_q <= cnt_q - 1'b1;                                // see R16 see R23
        end
        ST_HOLD:
        begin
          if (cnt_zero)
          begin
            unique case (cmd_q)
              CMD_STORE:  cnt_q <= CNT_W'(STORE_WAIT);            // see R23 see R24
              CMD_RECALL: cnt_q <= CNT_W'(RECALL_WAIT);           // see R13 see R24
              default:    cnt_q <= '0;
            endcase
            state_q <= ST_BUSY;
          end
          else
            cnt_q <= cnt_q - 1'b1;
        end
        ST_BUSY:
        begin
          if (cnt_zero)
            state_q <= ST_DONE;                                   // see R10 see R14
          else
            cnt_q <= cnt_q - 1'b1;
        end
        ST_DONE:
          state_q <= ST_IDLE;                                     // see R18
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pins
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
    begin
      O_MEM_CTL     <= CTL_IDLE;                                  // see R21
      O_ADDR_BUS    <= '0;
      O_DATA_BUS    <= '0;
      O_DATA_BUS_OE <= 1'b0;
    end
    else
    begin
      if (state_q == ST_IDLE && I_REQ_VALID)
      begin
        O_MEM_CTL     <= setup_ctl(I_REQ_CMD);                    // see R01
        O_ADDR_BUS    <= I_REQ_ADDR;                              // see R05
        O_DATA_BUS    <= I_REQ_WDATA;
        O_DATA_BUS_OE <= (I_REQ_CMD == CMD_WRITE);                // see R06
      end
      else if (state_q == ST_SETUP && cnt_zero)
        O_MEM_CTL <= strobe_ctl(cmd_q);
      else if (state_q == ST_STROBE && cnt_zero)
        O_MEM_CTL <= CTL_IDLE;                                    // see R18
      else if (state_q == ST_HOLD && cnt_zero)
        O_DATA_BUS_OE <= 1'b0;                                    // see R10
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Host handshake; read data taken at end of access time
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
    begin
      O_REQ_READY <= 1'b0;
      O_RSP_VALID <= 1'b0;
      O_RSP_RDATA <= '0;
      O_BUSY      <= 1'b1;
    end
    else
    begin
      O_REQ_READY <= (state_q == ST_DONE) || (state_q == ST_BOOT && cnt_zero);
      O_RSP_VALID <= (state_q == ST_DONE);                        // see R11
      O_BUSY      <= !((state_q == ST_DONE) || (state_q == ST_BOOT && cnt_zero) ||
                       (state_q == ST_IDLE && !I_REQ_VALID));     // see R24
      if (state_q == ST_STROBE && cnt_zero && cmd_q == CMD_READ)
        O_RSP_RDATA <= I_DATA_BUS;                                // see R03
    end
  end

  ////////////////////////////////////////////////////////////////////////
  a_rd_ctl: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (!O_MEM_CTL.chip_sel_n && !O_MEM_CTL.out_en_n) |-> O_MEM_CTL.write_en_n)
    else $error("Write enable low while output enable low"); // see R06
  a_store_order: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    ($fell(O_MEM_CTL.write_en_n) && !O_MEM_CTL.nonvolatile_select_n) |-> $past(!O_MEM_CTL.chip_sel_n))
    else $error("Store not entered by write enable"); // see R08
  a_nv_no_oe: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    !O_MEM_CTL.nonvolatile_select_n |-> !O_DATA_BUS_OE)
    else $error("Data driven in nonvolatile mode"); // see R10
  a_addr_stable: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (!O_MEM_CTL.chip_sel_n && !$past(O_MEM_CTL.chip_sel_n)) |-> $stable(O_ADDR_BUS))
    else $error("Address moved during access"); // see R05
  a_strobe_width: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    $fell(O_MEM_CTL.chip_sel_n) |-> !O_MEM_CTL.chip_sel_n [*3])
    else $error("Strobe shorter than 20 ns"); // see R16
  a_boot_idle: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (state_q == ST_BOOT) |-> (O_MEM_CTL == CTL_IDLE && O_BUSY))
    else $error("Access during power-up recall"); // see R21
  a_busy_ctl: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (state_q == ST_BUSY) |-> (O_MEM_CTL == CTL_IDLE && O_BUSY && !O_DATA_BUS_OE))
    else $error("Pins active during store or recall wait"); // see R13
  a_done_rsp: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (state_q == ST_DONE) |=> (O_RSP_VALID && O_REQ_READY))
    else $error("Completion not reported"); // see R24

endmodule : nvsc_ctrl

// file: nvsc_dev_model.sv
`timescale 1ns/100ps
module nvsc_dev_model
  import nvsc_pkg::*;
#(
  parameter int STORE_T   = 15,
  parameter int RECALL_T  = 8,
  parameter int RESTORE_T = 25
)
(
  input  wire logic              i_clk,
  input  wire nvsc_ctl_s         i_ctl,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_data,
  input  wire logic              i_data_oe,
  output logic [DATA_W-1:0]      o_data,
  output int                     o_stores,
  output int                     o_recalls,
  output int                     o_viol
);
  logic [DATA_W-1:0] sram [DEPTH];
  logic [DATA_W-1:0] nv   [DEPTH];
  int                busy;
  logic              st_q;
  logic              rc_q;
  logic              tgl_q;
  logic              rd;
  logic              wr;
  logic              st;
  logic              rc;
  assign rd = !i_ctl.chip_sel_n && !i_ctl.out_en_n && i_ctl.write_en_n && i_ctl.nonvolatile_select_n;
  assign wr = !i_ctl.chip_sel_n && !i_ctl.write_en_n && i_ctl.nonvolatile_select_n;
  assign st = !i_ctl.chip_sel_n && !i_ctl.write_en_n && i_ctl.out_en_n && !i_ctl.nonvolatile_select_n;
  assign rc = !i_ctl.chip_sel_n && !i_ctl.out_en_n && i_ctl.write_en_n && !i_ctl.nonvolatile_select_n;
  // Released bus toggles, so a stale byte never reads as good
  assign o_data = (busy == 0 && rd && !i_data_oe) ? sram[i_addr] : {DATA_W{tgl_q}} ^ 8'ha5;
  ////////////////////////////////////////////////////////////////
  initial
  begin
    foreach (nv[i]) nv[i] = DATA_W'(i) ^ 8'h3c;
    foreach (sram[i]) sram[i] = nv[i];
    busy = RESTORE_T;
    {st_q, rc_q, tgl_q} = 3'h0;
    {o_stores, o_recalls, o_viol} = '0;
  end
  always @(posedge i_clk)
  begin
    tgl_q <= !tgl_q;
    st_q  <= st;
    rc_q  <= rc;
    if (busy > 0 && (rd || wr))
      o_viol <= o_viol + 1;
    if (busy > 0)
      busy <= busy - 1;
    else if (st && !st_q)
    begin
      // Erase is folded into the copy
      foreach (nv[i]) nv[i] = sram[i];
      o_stores <= o_stores + 1;
      busy     <= STORE_T;
    end
    else if (rc && !rc_q)
    begin
      foreach (sram[i]) sram[i] = nv[i];
      o_recalls <= o_recalls + 1;
      busy      <= RECALL_T;
    end
    else if (wr)
      sram[i_addr] <= i_data;
  end
endmodule : nvsc_dev_model

// file: nvsc_ctrl_test.sv
`timescale 1ns/100ps
module nvsc_ctrl_test;
  import nvsc_pkg::*;
  localparam int SW = 20;
  localparam int RW = 30;
  localparam int CW = 10;
  logic              I_CORE_CLK  = 1'b0;
  logic              I_RST       = 1'b1;
  logic              I_REQ_VALID = 1'b0;
  nvsc_cmd_e         I_REQ_CMD   = CMD_READ;
  logic [ADDR_W-1:0] I_REQ_ADDR  = '0;
  logic [DATA_W-1:0] I_REQ_WDATA = '0;
  logic              O_REQ_READY, O_RSP_VALID, O_BUSY, O_DATA_BUS_OE;
  logic [DATA_W-1:0] O_RSP_RDATA, O_DATA_BUS, dev_data;
  nvsc_ctl_s         O_MEM_CTL;
  logic [ADDR_W-1:0] O_ADDR_BUS;
  wire  [DATA_W-1:0] I_DATA_BUS = O_DATA_BUS_OE ? O_DATA_BUS : dev_data;
  int                num_errors = 0;
  int                n_checks = 0;
  int                stores, recalls, viol;
  always #4 I_CORE_CLK = !I_CORE_CLK;
  nvsc_ctrl #(.STORE_WAIT(SW), .RESTORE_WAIT(RW), .RECALL_WAIT(CW)) u_nvsc_ctrl
    (.I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_REQ_VALID(I_REQ_VALID), .I_REQ_CMD(I_REQ_CMD),
     .I_REQ_ADDR(I_REQ_ADDR), .I_REQ_WDATA(I_REQ_WDATA), .O_REQ_READY(O_REQ_READY),
     .O_RSP_VALID(O_RSP_VALID), .O_RSP_RDATA(O_RSP_RDATA), .O_BUSY(O_BUSY), .O_MEM_CTL(O_MEM_CTL),
     .O_ADDR_BUS(O_ADDR_BUS), .I_DATA_BUS(I_DATA_BUS), .O_DATA_BUS(O_DATA_BUS), .O_DATA_BUS_OE(O_DATA_BUS_OE));
  nvsc_dev_model u_nvsc_dev_model
    (.i_clk(I_CORE_CLK), .i_ctl(O_MEM_CTL), .i_addr(O_ADDR_BUS), .i_data(I_DATA_BUS),
     .i_data_oe(O_DATA_BUS_OE), .o_data(dev_data), .o_stores(stores), .o_recalls(recalls), .o_viol(viol));
  ////////////////////////////////////////////////////////////////
  task automatic chk_byte(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %0t: byte got %h expected %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_cnt(input int got, input int exp);
    n_checks++;
    if (got != exp)
    begin
      num_errors++;
      $display("Error %0t: count got %0d expected %0d", $time, got, exp);
    end
  endtask : chk_cnt
  // Bounded waits, so a stuck controller shows as a miss
  task automatic run(input nvsc_cmd_e cmd, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    while (O_BUSY !== 1'b0 && n < 400)
    begin
      @(negedge I_CORE_CLK);
      n++;
    end
    I_REQ_VALID = 1'b1;
    I_REQ_CMD   = cmd;
    I_REQ_ADDR  = a;
    I_REQ_WDATA = d;
    @(negedge I_CORE_CLK);
    I_REQ_VALID = 1'b0;
    while (O_RSP_VALID !== 1'b1 && n < 800)
    begin
      @(negedge I_CORE_CLK);
      n++;
    end
    chk_cnt(int'(n < 800), 1);
    chk_cnt(int'(O_REQ_READY === 1'b1), 1);
  endtask : run
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    run(CMD_READ, a, 8'h00);
    chk_byte(O_RSP_RDATA, exp);
  endtask : rd_chk
  ////////////////////////////////////////////////////////////////
  task automatic t_boot();
    int n;
    n = 0;
    repeat (12) @(negedge I_CORE_CLK);
    I_RST = 1'b0;
    while (O_BUSY !== 1'b0 && n < 400)
    begin
      @(negedge I_CORE_CLK);
      n++;
    end
    chk_cnt(int'(n >= RW && n < 400), 1);
    chk_cnt(int'(O_REQ_READY === 1'b1), 1);
    chk_cnt(viol, 0);
    $display("test boot done");
  endtask : t_boot
  task automatic t_rw();
    run(CMD_WRITE, 11'h000, 8'h11);
    run(CMD_WRITE, 11'h7ff, 8'hee);
    run(CMD_WRITE, 11'h005, 8'h5a);
    rd_chk(11'h000, 8'h11);
    rd_chk(11'h7ff, 8'hee);
    rd_chk(11'h009, 8'h35);
    $display("test rw done");
  endtask : t_rw
  task automatic t_nv();
    run(CMD_STORE, 11'h000, 8'h00);
    chk_cnt(stores, 1);
    run(CMD_WRITE, 11'h005, 8'h00);
    rd_chk(11'h005, 8'h00);
    run(CMD_RECALL, 11'h000, 8'h00);
    chk_cnt(recalls, 1);
    rd_chk(11'h005, 8'h5a);
    run(CMD_RECALL, 11'h000, 8'h00);
    chk_cnt(recalls, 2);
    rd_chk(11'h7ff, 8'hee);
    chk_cnt(stores, 1);
    chk_cnt(viol, 0);
    $display("test nv done");
  endtask : t_nv
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  initial
  begin
    #40000;
    num_errors++;
    $display("Error %0t: watchdog expired", $time);
    stop_test();
  end
  initial
  begin
    t_boot();
    t_rw();
    t_nv();
    stop_test();
  end
endmodule : nvsc_ctrl_test
